// file: src/fsb_regs.svh
// register offsets, field positions, reset values and timing counts
// for the frame sync output block; included by its bare name
`ifndef FSB_REGS_SVH
`define FSB_REGS_SVH

// global sysref control register
`define FSB_ADDR_SYS 8'h19
`define FSB_BIAS_TYPE_BIT 7
`define FSB_DLC_LSB 5
`define FSB_DLC_MSB 6

// per output source and phase registers
`define FSB_ADDR_SEL_A0 8'h28
`define FSB_ADDR_SEL_A1 8'h29
`define FSB_ADDR_SEL_A2 8'h2A
`define FSB_ADDR_SEL_B0 8'h38
`define FSB_ADDR_SEL_B1 8'h39
`define FSB_ADDR_SEL_C0 8'h48
`define FSB_ADDR_SEL_C1 8'h49
`define FSB_ADDR_SEL_D 8'h58
`define FSB_SRC_BIT 4
`define FSB_PHASE_LSB 1
`define FSB_PHASE_MSB 3

// per output bias and style registers
`define FSB_ADDR_BIAS_A0 8'h2C
`define FSB_ADDR_BIAS_A1 8'h2D
`define FSB_ADDR_BIAS_A2 8'h2E
`define FSB_ADDR_BIAS_B0 8'h3C
`define FSB_ADDR_BIAS_B1 8'h3D
`define FSB_ADDR_BIAS_C0 8'h4C
`define FSB_ADDR_BIAS_C1 8'h4D
`define FSB_ADDR_BIAS_D 8'h5C
`define FSB_HOLD_BIT 5
`define FSB_STYLE_BIT 4

// reset values
`define FSB_RST_SRC 1'h1
`define FSB_RST_PHASE 3'h0
`define FSB_RST_HOLD 1'h0
`define FSB_RST_STYLE 1'h0
`define FSB_RST_BIAS_TYPE 1'h1
`define FSB_RST_DLC 2'h0

// timing: one delay cell and the clock period, in ps
`define FSB_DELAY_CELL_PS 131
`define FSB_CLK_PERIOD_PS 10000

`endif

// file: src/fsb_pkg.sv
// types shared by the frame sync output block
// no surroundings assumed
package fsb_pkg;

    // lane bias sequencing: waiting for first reference edge, or running
    typedef enum logic {
        FSB_ST_IDLE,
        FSB_ST_RUN
    } fsb_state_t;

    // output electrical style
    typedef enum logic {
        FSB_STYLE_LVDS,
        FSB_STYLE_ECL
    } fsb_style_t;

endpackage

// file: src/fsb_lane_if.sv
// configuration and signals handed from the register side to one lane
// assumes one instance per output, driven by the top module
`timescale 1ns/1ps
`default_nettype none

interface fsb_lane_if;
    logic src_sel;
    logic [2:0] phase;
    logic [1:0] dlc;
    logic bias_type;
    logic bias_hold;
    logic style;
    logic ref_rise;
    logic sysref;
    logic chan_clk;

    modport ctrl (
        output src_sel, phase, dlc, bias_type, bias_hold, style,
        output ref_rise, sysref, chan_clk
    );
    modport lane (
        input src_sel, phase, dlc, bias_type, bias_hold, style,
        input ref_rise, sysref, chan_clk
    );
endinterface

`default_nettype wire

// file: src/fsb_lane.sv
// one frame sync output: source select, phase delay line, bias sequencing
// assumes all inputs synchronous to clock; outputs are flip-flops
`timescale 1ns/1ps
`default_nettype none
`include "fsb_regs.svh"

module fsb_lane
    import fsb_pkg::*;
#(
    parameter int PHASE_MAX = 7,
    parameter int DLC_MAX = 3
)(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // configuration
    fsb_lane_if.lane cfg,
    // output pair and crosspoint hold
    output logic out_p,
    output logic out_n,
    output logic out_xpt
);

    // clock cycles per delay cell, never below one
    localparam int CELL_RAW =
        (`FSB_DELAY_CELL_PS + `FSB_CLK_PERIOD_PS - 1) / `FSB_CLK_PERIOD_PS;
    localparam int CELL_CYC = (CELL_RAW < 1) ? 1 : CELL_RAW;
    localparam int DEPTH = PHASE_MAX * (DLC_MAX + 1) * CELL_CYC;
    localparam int TW = $clog2(DEPTH + 1);

    logic src;
    logic delayed;
    logic [TW-1:0] tap;
    logic [DEPTH-1:0] line_r;
    fsb_state_t st_r;
    logic p_nxt;
    logic n_nxt;
    logic x_nxt;

    // source choice
    always_comb
    begin
        if (cfg.src_sel)
            src = cfg.sysref;
        else
            src = cfg.chan_clk;
    end

    // delay line in cells: code times (step setting plus one)
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            line_r <= '0;
        else
            line_r <= {line_r[DEPTH-2:0], src};
    end

    always_comb
    begin
        tap = TW'(32'(cfg.phase) * (32'(cfg.dlc) + 1) * CELL_CYC);
        if (tap == '0)
            delayed = src;
        else
            delayed = line_r[tap - TW'(1)];
    end

    // first rising reference edge starts toggling of LVDS outputs whose bias hold is clear; ECL outputs toggle without it
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            st_r <= FSB_ST_IDLE;
        else
        begin
            case (st_r)
                FSB_ST_IDLE:
                    if (cfg.ref_rise)
                        st_r <= FSB_ST_RUN;
                FSB_ST_RUN:
                    st_r <= FSB_ST_RUN;
                default:
                    st_r <= FSB_ST_IDLE;
            endcase
        end
    end

    // output level selection
    always_comb
    begin
        p_nxt = delayed;
        n_nxt = ~delayed;
        x_nxt = 1'b0;
        if (cfg.style == FSB_STYLE_ECL)
        begin
            p_nxt = delayed;
            n_nxt = ~delayed;
        end
        else if (cfg.bias_hold)
        begin
            p_nxt = 1'b0;
            if (cfg.bias_type)
            begin
                n_nxt = 1'b0;
                x_nxt = 1'b1;
            end
            else
                n_nxt = 1'b1;
        end
        else if (st_r == FSB_ST_IDLE)
        begin
            p_nxt = 1'b0;
            if (cfg.bias_type)
            begin
                n_nxt = 1'b0;
                x_nxt = 1'b1;
            end
            else
                n_nxt = 1'b1;
        end
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            out_p <= 1'b0;
            out_n <= 1'b1;
            out_xpt <= 1'b0;
        end
        else
        begin
            out_p <= p_nxt;
            out_n <= n_nxt;
            out_xpt <= x_nxt;
        end
    end

endmodule // fsb_lane

`default_nettype wire

// file: src/fsb_top.sv
// frame sync output control: eight outputs, source, phase delay and bias
// assumes a simple register port and inputs synchronous to clock
//
// The address-and-strobe port and the address map were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fsb_regs.svh"

module fsb_top
    import fsb_pkg::*;
#(
    parameter int NOUT = 8,
    parameter int NCHAN = 4
)(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // signal sources
    input wire logic [NCHAN-1:0] chan_clk,
    input wire logic sysref_in,
    input wire logic ref_in,
    // outputs
    output logic [NOUT-1:0] frame_sync_out,
    output logic [NOUT-1:0] frame_sync_out_neg,
    output logic [NOUT-1:0] crosspoint_level
);

    // source/phase register lookup: {hit, index}
    function automatic logic [3:0] sel_index(input logic [7:0] a);
        case (a)
            `FSB_ADDR_SEL_A0: sel_index = 4'h8;
            `FSB_ADDR_SEL_A1: sel_index = 4'h9;
            `FSB_ADDR_SEL_A2: sel_index = 4'hA;
            `FSB_ADDR_SEL_B0: sel_index = 4'hB;
            `FSB_ADDR_SEL_B1: sel_index = 4'hC;
            `FSB_ADDR_SEL_C0: sel_index = 4'hD;
            `FSB_ADDR_SEL_C1: sel_index = 4'hE;
            `FSB_ADDR_SEL_D: sel_index = 4'hF;
            default: sel_index = 4'h0;
        endcase
    endfunction

    // bias/style register lookup: {hit, index}
    function automatic logic [3:0] bias_index(input logic [7:0] a);
        case (a)
            `FSB_ADDR_BIAS_A0: bias_index = 4'h8;
            `FSB_ADDR_BIAS_A1: bias_index = 4'h9;
            `FSB_ADDR_BIAS_A2: bias_index = 4'hA;
            `FSB_ADDR_BIAS_B0: bias_index = 4'hB;
            `FSB_ADDR_BIAS_B1: bias_index = 4'hC;
            `FSB_ADDR_BIAS_C0: bias_index = 4'hD;
            `FSB_ADDR_BIAS_C1: bias_index = 4'hE;
            `FSB_ADDR_BIAS_D: bias_index = 4'hF;
            default: bias_index = 4'h0;
        endcase
    endfunction

    // channel feeding each output: A0-A2, B0-B1, C0-C1, D
    function automatic int chan_of(input int i);
        if (i < 3)
            chan_of = 0;
        else if (i < 5)
            chan_of = 1;
        else if (i < 7)
            chan_of = 2;
        else
            chan_of = 3;
    endfunction

    // global register decode, shared by write and read side
    function automatic logic is_sys(input logic [7:0] a);
        is_sys = (a == `FSB_ADDR_SYS);
    endfunction

    // read back word of a source/phase register
    function automatic logic [7:0] pack_sel(input logic s,
        input logic [2:0] p);
        pack_sel = 8'h00;
        pack_sel[`FSB_SRC_BIT] = s;
        pack_sel[`FSB_PHASE_MSB:`FSB_PHASE_LSB] = p;
    endfunction

    // read back word of a bias/style register
    function automatic logic [7:0] pack_bias(input logic h,
        input logic st);
        pack_bias = 8'h00;
        pack_bias[`FSB_HOLD_BIT] = h;
        pack_bias[`FSB_STYLE_BIT] = st;
    endfunction

    // read back word of the global register
    function automatic logic [7:0] pack_sys(input logic t,
        input logic [1:0] d);
        pack_sys = 8'h00;
        pack_sys[`FSB_BIAS_TYPE_BIT] = t;
        pack_sys[`FSB_DLC_MSB:`FSB_DLC_LSB] = d;
    endfunction

    logic [NOUT-1:0] src_sel_r;
    logic [2:0] phase_r [NOUT];
    logic [NOUT-1:0] hold_r;
    logic [NOUT-1:0] style_r;
    logic bias_type_r;
    logic [1:0] dlc_r;
    logic ref_prev_r;
    logic ref_rise;
    logic [3:0] wsel;
    logic [3:0] wbias;
    logic [3:0] rsel;
    logic [3:0] rbias;
    logic [7:0] rdata_nxt;

    assign wsel = sel_index(reg_addr);
    assign wbias = bias_index(reg_addr);
    assign rsel = wsel;
    assign rbias = wbias;

    // per output source select and phase code
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            src_sel_r <= {NOUT{`FSB_RST_SRC}};
            for (int i = 0; i < NOUT; i++)
                phase_r[i] <= `FSB_RST_PHASE;
        end
        else if (reg_wr && wsel[3])
        begin
            src_sel_r[wsel[2:0]] <= reg_wdata[`FSB_SRC_BIT];
            phase_r[wsel[2:0]] <=
                reg_wdata[`FSB_PHASE_MSB:`FSB_PHASE_LSB];
        end
    end

    // per output bias hold and style
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            hold_r <= {NOUT{`FSB_RST_HOLD}};
            style_r <= {NOUT{`FSB_RST_STYLE}};
        end
        else if (reg_wr && wbias[3])
        begin
            hold_r[wbias[2:0]] <= reg_wdata[`FSB_HOLD_BIT];
            style_r[wbias[2:0]] <= reg_wdata[`FSB_STYLE_BIT];
        end
    end

    // global bias type and delay step setting
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            bias_type_r <= `FSB_RST_BIAS_TYPE;
            dlc_r <= `FSB_RST_DLC;
        end
        else if (reg_wr && is_sys(reg_addr))
        begin
            bias_type_r <= reg_wdata[`FSB_BIAS_TYPE_BIT];
            dlc_r <= reg_wdata[`FSB_DLC_MSB:`FSB_DLC_LSB];
        end
    end

    // read mux, unmapped and reserved bits read zero
    always_comb
    begin
        rdata_nxt = 8'h00;
        if (rsel[3])
            rdata_nxt = pack_sel(src_sel_r[rsel[2:0]], phase_r[rsel[2:0]]);
        else if (rbias[3])
            rdata_nxt = pack_bias(hold_r[rbias[2:0]], style_r[rbias[2:0]]);
        else if (is_sys(reg_addr))
            rdata_nxt = pack_sys(bias_type_r, dlc_r);
    end

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            reg_rdata <= 8'h00;
        else if (reg_rd)
            reg_rdata <= rdata_nxt;
        else
            reg_rdata <= 8'h00;
    end

    // reference input rising edge
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
            ref_prev_r <= 1'b1; // a level held through reset is no edge
        else
            ref_prev_r <= ref_in;
    end

    assign ref_rise = ref_in & ~ref_prev_r;

    // one lane per output
    generate
        for (genvar g = 0; g < NOUT; g++)
        begin : g_lane
            fsb_lane_if lif ();

            assign lif.src_sel = src_sel_r[g];
            assign lif.phase = phase_r[g];
            assign lif.dlc = dlc_r;
            assign lif.bias_type = bias_type_r;
            assign lif.bias_hold = hold_r[g];
            assign lif.style = style_r[g];
            assign lif.ref_rise = ref_rise;
            assign lif.sysref = sysref_in;
            assign lif.chan_clk = chan_clk[chan_of(g)];

            fsb_lane u_lane (
                .clock(clock),
                .nrst(nrst),
                .cfg(lif.lane),
                .out_p(frame_sync_out[g]),
                .out_n(frame_sync_out_neg[g]),
                .out_xpt(crosspoint_level[g])
            );
        end
    endgenerate

endmodule // fsb_top

`default_nettype wire

// file: verification/fsb_conv_model.sv
// receiver model of the converters fed by the frame sync outputs
// assumes pairs and crosspoint flags arrive registered on clock
`timescale 1ns/1ps
`default_nettype none
module fsb_conv_model
(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // received pairs
    input wire logic [7:0] sync_p,
    input wire logic [7:0] sync_n,
    input wire logic [7:0] sync_xpt,
    // rising edges seen on lane 0
    output logic [15:0] rise_cnt
);
    logic high_r;
    logic high_nxt;
    assign high_nxt = sync_p[0] & ~sync_n[0] & ~sync_xpt[0];
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            high_r <= 1'b0;
            rise_cnt <= 16'h0000;
        end
        else
        begin
            high_r <= high_nxt;
            if (high_nxt && !high_r)
                rise_cnt <= rise_cnt + 16'h0001;
        end
    end
endmodule // fsb_conv_model
`default_nettype wire

// file: verification/fsb_top_assertions.sv
// port checks for the frame sync output block
// assumes one clock domain; bound onto fsb_top below
`timescale 1ns/1ps
`default_nettype none
`include "fsb_regs.svh"
module fsb_top_assertions
#(
    parameter int NOUT = 8,
    parameter int NCHAN = 4
)(
    // clock and reset
    input wire logic clock,
    input wire logic nrst,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    // sources
    input wire logic [NCHAN-1:0] chan_clk,
    input wire logic sysref_in,
    input wire logic ref_in,
    // outputs
    input wire logic [NOUT-1:0] frame_sync_out,
    input wire logic [NOUT-1:0] frame_sync_out_neg,
    input wire logic [NOUT-1:0] crosspoint_level
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (!nrst);
    sequence wr_rd(logic [7:0] a);
        reg_wr && reg_addr == a ##1 reg_rd && reg_addr == a;
    endsequence
    a_type_readback: assert property (wr_rd(`FSB_ADDR_SYS)
        |=> reg_rdata[7] == $past(reg_wdata[7], 2))
        else $error("bias type read back wrong");
    a_src_readback: assert property (wr_rd(`FSB_ADDR_SEL_A0)
        |=> reg_rdata[4] == $past(reg_wdata[4], 2))
        else $error("source select read back wrong");
    a_phase_readback: assert property (wr_rd(`FSB_ADDR_SEL_A0)
        |=> reg_rdata[3:1] == $past(reg_wdata[3:1], 2))
        else $error("phase code read back wrong");
    a_hold_readback: assert property (wr_rd(`FSB_ADDR_BIAS_A0)
        |=> reg_rdata[5] == $past(reg_wdata[5], 2))
        else $error("bias hold read back wrong");
    a_sel_reserved: assert property ($past(reg_rd)
        && $past(reg_addr) == `FSB_ADDR_SEL_A0
        |-> reg_rdata[7:5] == 3'h0 && !reg_rdata[0])
        else $error("reserved select bits not zero");
    a_rd_pulse: assert property (reg_rd ##1 !reg_rd
        |=> reg_rdata == 8'h00)
        else $error("read data stood too long");
    a_xpt_sides: assert property (
        (crosspoint_level & (frame_sync_out | frame_sync_out_neg)) == '0)
        else $error("crosspoint with a side driven");
    a_pair_compl: assert property (
        ((frame_sync_out ^ frame_sync_out_neg) | crosspoint_level) == '1)
        else $error("pair sides not complementary");
    c_xpt_lane: cover property (crosspoint_level[0]);
    c_sys_read: cover property (reg_rd && reg_addr == `FSB_ADDR_SYS);
    c_toggle: cover property ($rose(frame_sync_out[0]));
endmodule // fsb_top_assertions
bind fsb_top fsb_top_assertions #(.NOUT(NOUT), .NCHAN(NCHAN))
    fsb_top_assertions_i (.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata, .chan_clk, .sysref_in, .ref_in, .frame_sync_out,
    .frame_sync_out_neg, .crosspoint_level);
`default_nettype wire

// file: verification/fsb_top_test.sv
// self-checking bench for the frame sync output block
// assumes design, converter model and checker compiled before it
`timescale 1ns/1ps
`default_nettype none
`include "fsb_regs.svh"
module fsb_top_test;
    logic clock, nrst, reg_wr, reg_rd, sysref_in, ref_in, rd_d, use_chan;
    logic chk_en;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, q_out, q_neg, q_xpt, ph;
    logic [3:0] chan_clk;
    logic [15:0] rise_cnt;
    logic [31:0] hist;
    logic [7:0] rd_q[$];
    int n_mismatch, tests_run, lag;
    fsb_top fsb_top_i (.clock, .nrst, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .chan_clk, .sysref_in, .ref_in,
        .frame_sync_out(q_out), .frame_sync_out_neg(q_neg),
        .crosspoint_level(q_xpt));
    fsb_conv_model fsb_conv_model_i (.clock, .nrst, .sync_p(q_out),
        .sync_n(q_neg), .sync_xpt(q_xpt), .rise_cnt);
    task automatic check(input string nm, input logic [7:0] seen,
        input logic [7:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic bus(input logic w, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= w;
        reg_rd <= ~w;
        if (!w)
            rd_q.push_back(d);
    endtask
    task automatic idle(input int n);
        @(posedge clock);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        repeat (n) @(posedge clock);
    endtask
    task automatic pin(input logic [2:0] e);
        @(negedge clock);
        check("lane0", {5'h00, q_out[0], q_neg[0], q_xpt[0]},
            {5'h00, e});
    endtask
    task automatic done(input string nm);
        $display("test %s done", nm);
    endtask
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    always @(posedge clock)
    begin
        sysref_in <= 1'($urandom);
        chan_clk <= 4'($urandom);
        rd_d <= reg_rd;
    end
    always @(negedge clock)
    begin
        if (rd_d)
            check("reg_rdata", reg_rdata, rd_q.pop_front());
        if (chk_en)
            check("delayed", {7'h00, q_out[0]}, {7'h00, hist[lag]});
        hist = {hist[30:0], use_chan ? chan_clk[0] : sysref_in};
    end
    initial
    begin
        nrst = 1'b0;
        {reg_addr, reg_wdata, reg_wr, reg_rd, ref_in} = '0;
        {use_chan, chk_en, ph} = '0;
        n_mismatch = 0;
        tests_run = 0;
        lag = 0;
        void'($urandom(32'h1F4C));
        repeat (16) @(posedge clock);
        nrst <= 1'b1;
        bus(0, `FSB_ADDR_SYS, 8'h80);
        bus(0, `FSB_ADDR_SEL_A0, 8'h10);
        bus(0, 8'h00, 8'h00);
        idle(2);
        pin(3'b001);
        check("all_p", q_out, 8'h00);
        check("all_xpt", q_xpt, 8'hFF);
        done("reset");
        bus(1, `FSB_ADDR_SYS, 8'h00);
        idle(2);
        pin(3'b010);
        check("all_neg", q_neg, 8'hFF);
        bus(1, `FSB_ADDR_BIAS_A0, 8'h20);
        bus(0, `FSB_ADDR_BIAS_A0, 8'h20);
        idle(1);
        ref_in <= 1'b1;
        idle(6);
        pin(3'b010);
        bus(1, `FSB_ADDR_SYS, 8'h80);
        idle(6);
        pin(3'b001);
        check("rises", rise_cnt[7:0], 8'h00);
        done("bias");
        bus(1, `FSB_ADDR_BIAS_A0, 8'h30);
        for (int s = 0; s < 4; s++)
        begin
            ph = (s == 3) ? 8'h07 : 8'($urandom_range(6));
            if (s == 2)
                bus(1, `FSB_ADDR_BIAS_A0, 8'h00);
            bus(1, `FSB_ADDR_SYS, {s[0], s[1:0], 5'h00});
            bus(0, `FSB_ADDR_SYS, {s[0], s[1:0], 5'h00});
            bus(1, `FSB_ADDR_SEL_A0, {3'h0, s[0], ph[2:0], 1'b0});
            bus(0, `FSB_ADDR_SEL_A0, {3'h0, s[0], ph[2:0], 1'b0});
            lag = ph * (s + 1);
            use_chan = ~s[0];
            idle(32);
            chk_en = 1'b1;
            idle(40);
            chk_en = 1'b0;
        end
        done("delay");
        nrst <= 1'b0;
        ref_in <= 1'b0;
        idle(3);
        nrst <= 1'b1;
        idle(1);
        pin(3'b001);
        idle(0);
        ref_in <= 1'b1;
        idle(0);
        pin(3'b001);
        lag = 0;
        use_chan = 1'b0;
        idle(2);
        chk_en = 1'b1;
        idle(40);
        chk_en = 1'b0;
        check("started", {7'h00, |rise_cnt}, 8'h01);
        done("restart");
        give_verdict;
    end
    initial
    begin
        repeat (3000) @(posedge clock);
        n_mismatch++;
        give_verdict;
    end
endmodule // fsb_top_test
`default_nettype wire
